// ==== design/cepv_core.sv ====
// CPU event arbitration and vectoring with an AXI4-Lite register port.
// Assumes event lines, program counters and autovector come from logic on I_CLOCK
// and stay pending until this block reports them taken.
//
// Function
// RL1 - Fixed 28-level ranking; reset first at fixed vector, NMI and scall off base.
// RL2 - Debug halt ranks second and uses the handler address the debug unit gives.
// RL3 - Data-fetch bus error at priority five, vector base plus eight.
// RL4 - Instruction-fetch bus error at priority six, vector base plus twelve.
// RL5 - Faults save the program counter of the offending instruction.
// RL6 - Interrupts, NMI, bus errors, breakpoints, debug save first unfinished; interrupts autovectored.
// RL7 - Taking an event masks equal and lower sources; critical events stay unmaskable; taking debug halt here leaves the mask unchanged.
// RL8 - Interrupt controller supplies a 14-bit autovector added to the vector base.
// RL9 - Events of the oldest pipeline instruction go first, whatever their rank.
// RL10 - Floating-point, coprocessor-absent and page-modified events are never raised.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module cepv_core
  import cepv_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic [EVT_N-1:0] I_EVT_OLD,
  input wire logic [EVT_N-1:0] I_EVT_YOUNG,
  input wire logic [31:0] I_PC_OLD,
  input wire logic [31:0] I_PC_YOUNG,
  input wire logic [31:0] I_DBG_HANDLER,
  input wire logic [AUTOVEC_W-1:0] I_AUTOVEC,
  output logic O_TAKE,
  output logic [IDX_W-1:0] O_PRIO,
  output logic [31:0] O_HANDLER,
  output logic [31:0] O_RET_ADDR,
  output logic O_TAKEN_OLD,
  output logic [SR_W-1:0] O_SR_MASK,
  output logic O_IRQ,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);
  typedef struct packed {
    logic [31:0] event_vector_base;
    logic [SR_W-1:0] sr_mask;
    logic [ST_W-1:0] irq_sts;
    logic [ST_W-1:0] irq_msk;
    logic irq;
    logic boot;
    logic take;
    logic [IDX_W-1:0] prio;
    logic [31:0] handler;
    logic [31:0] ret;
    logic taken_old;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cepv_state_t;

  localparam cepv_state_t ST_RST = '{
    sr_mask: SR_MASK_RST, boot: 1'b1, awready: 1'b1, wready: 1'b1, arready: 1'b1,
    default: '0
  };

  cepv_state_t st;
  cepv_state_t nx;
  logic [EVT_N-1:0] enable;
  logic [EVT_N-1:0] eff_old;
  logic [EVT_N-1:0] eff_young;
  logic old_hit;
  logic young_hit;
  logic [IDX_W-1:0] old_idx;
  logic [IDX_W-1:0] young_idx;
  logic [IDX_W-1:0] sel_prio;
  logic [31:0] sel_pc;

  // Sources that may be taken now; unused slots and masked levels drop out
  always_comb begin
    enable = ~EVT_NONSRC; // RL10
    for (int n = 0; n < 4; n++) begin
      // Level n sits at priority eleven minus n
      if (st.sr_mask[SR_GM] || st.sr_mask[SR_I0M + n]) begin
        enable[int'(P_INT0) - 1 - n] = 1'b0; // RL7
      end
    end
    eff_old = I_EVT_OLD & enable;
    eff_young = I_EVT_YOUNG & enable;
  end

  // One encoder per pipeline stage
  cepv_prio_enc #(.N(EVT_N), .W(IDX_W)) u_enc_old (
    .i_req(eff_old),
    .o_found(old_hit),
    .o_index(old_idx)
  );

  cepv_prio_enc #(.N(EVT_N), .W(IDX_W)) u_enc_young (
    .i_req(eff_young),
    .o_found(young_hit),
    .o_index(young_idx)
  );

  // The older instruction wins even against a higher young event
  always_comb begin
    if (old_hit) begin
      sel_prio = old_idx + 5'h01; // RL9
      sel_pc = I_PC_OLD;
    end else begin
      sel_prio = young_idx + 5'h01;
      sel_pc = I_PC_YOUNG;
    end
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Whole next state: bus slave, register file, arbitration
  always_comb begin
    logic [ADDR_W-1:0] ra;
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;
    nx = st;
    ra = I_ARADDR;
    st_set = '0;
    st_clr = '0;
    nx.take = 1'b0;

    // Write address and data in either order
    if (I_AWVALID && st.awready) begin
      nx.aw_got = 1'b1;
      nx.awaddr = I_AWADDR;
    end
    if (I_WVALID && st.wready) begin
      nx.w_got = 1'b1;
      nx.wdata = I_WDATA;
      nx.wstrb = I_WSTRB;
    end
    if (st.bvalid && I_BREADY) begin
      nx.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = RESP_OKAY;
      case ({st.awaddr[ADDR_W-1:2], 2'b00})
        REG_EVENT_VECTOR_BASE: nx.event_vector_base = merge(st.event_vector_base, st.wdata, st.wstrb) & ~32'h3;
        REG_SRMASK: begin
          if (st.wstrb[0]) begin
            nx.sr_mask = st.wdata[SR_W-1:0];
          end
        end
        REG_IRQ_STS: begin
          if (st.wstrb[0]) begin
            st_clr = st.wdata[ST_W-1:0];
          end
        end
        REG_IRQ_MSK: begin
          if (st.wstrb[0]) begin
            nx.irq_msk = st.wdata[ST_W-1:0];
          end
        end
        REG_HANDLER, REG_RETADDR, REG_PRIO: nx.bresp = RESP_OKAY;
        default: nx.bresp = RESP_SLVERR;
      endcase
    end

    // Read channel: one read in flight
    if (st.rvalid && I_RREADY) begin
      nx.rvalid = 1'b0;
    end
    if (I_ARVALID && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp = RESP_OKAY;
      case ({ra[ADDR_W-1:2], 2'b00})
        REG_EVENT_VECTOR_BASE: nx.rdata = st.event_vector_base;
        REG_SRMASK: nx.rdata = 32'(st.sr_mask);
        REG_HANDLER: nx.rdata = st.handler;
        REG_RETADDR: nx.rdata = st.ret;
        REG_PRIO: nx.rdata = 32'(st.prio);
        REG_IRQ_STS: nx.rdata = 32'(st.irq_sts);
        REG_IRQ_MSK: nx.rdata = 32'(st.irq_msk);
        default: begin
          nx.rdata = '0;
          nx.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Event acceptance; requests seen during the reset slot wait a cycle
    if (st.boot) begin
      nx.boot = 1'b0;
      nx.take = 1'b1;
      nx.prio = P_RESET; // RL1
      nx.handler = RESET_VEC; // RL1
      nx.ret = '0;
      nx.taken_old = 1'b1;
      nx.sr_mask = SR_MASK_RST;
    end else if (old_hit || young_hit) begin
      nx.take = 1'b1;
      nx.prio = sel_prio;
      nx.taken_old = old_hit;
      if (sel_prio == P_DBG) begin
        nx.handler = I_DBG_HANDLER; // RL2
        st_set[ST_DBG] = 1'b1;
      end else if (sel_prio >= P_INT3 && sel_prio <= P_INT0) begin
        nx.handler = st.event_vector_base + 32'(I_AUTOVEC); // RL6 RL8
        st_set[ST_INT] = 1'b1;
        for (int n = 0; n < 4; n++) begin
          // Same and lower levels masked; NMI and faults stay live
          // Level n sits at priority eleven minus n, so lower levels have larger numbers
          if (int'(sel_prio) <= int'(P_INT0) - n) begin
            nx.sr_mask[SR_I0M + n] = 1'b1; // RL7
          end
        end
      end else begin
        nx.handler = st.event_vector_base + 32'(cepv_offset(sel_prio)); // RL1 RL3 RL4
        if (sel_prio != P_SCALL) begin
          st_set[ST_EXC] = 1'b1;
          nx.sr_mask = SR_MASK_RST; // RL7
        end
      end
      case (cepv_ret_kind(sel_prio))
        CEPV_RET_OFFEND: nx.ret = sel_pc; // RL5
        CEPV_RET_FIRST: nx.ret = I_PC_OLD; // RL6
        CEPV_RET_SCALL: nx.ret = sel_pc + SCALL_STEP;
        default: nx.ret = '0;
      endcase
    end

    // Set beats a same-cycle write-one clear
    nx.irq_sts = (st.irq_sts & ~st_clr) | st_set;
    nx.irq = |(nx.irq_sts & nx.irq_msk);
    nx.awready = !nx.aw_got && !nx.bvalid;
    nx.wready = !nx.w_got && !nx.bvalid;
    nx.arready = !nx.rvalid;
  end

  // State register; reset loads constants only
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  // Every output is a state bit
  assign O_TAKE = st.take;
  assign O_PRIO = st.prio;
  assign O_HANDLER = st.handler;
  assign O_RET_ADDR = st.ret;
  assign O_TAKEN_OLD = st.taken_old;
  assign O_SR_MASK = st.sr_mask;
  assign O_IRQ = st.irq;
  assign O_AWREADY = st.awready;
  assign O_WREADY = st.wready;
  assign O_BRESP = st.bresp;
  assign O_BVALID = st.bvalid;
  assign O_ARREADY = st.arready;
  assign O_RDATA = st.rdata;
  assign O_RRESP = st.rresp;
  assign O_RVALID = st.rvalid;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_took(logic [IDX_W-1:0] p);
    O_TAKE && O_PRIO == p;
  endsequence

  a_reset_vector_first: assert property (st.boot |=> s_took(P_RESET) ##0 O_HANDLER == RESET_VEC) // RL1
    else $error("reset event not taken first at reset vector");
  a_nmi_vector_base: assert property (s_took(P_NMI) |-> O_HANDLER == $past(st.event_vector_base) + 32'h10) // RL1
    else $error("NMI handler address wrong");
  a_scall_vector_ret: assert property (s_took(P_SCALL) |->
      O_HANDLER == $past(st.event_vector_base) + 32'h100 && O_RET_ADDR == $past(sel_pc) + 32'h2) // RL1
    else $error("supervisor call vector or return wrong");
  a_debug_handler_pass: assert property (s_took(P_DBG) |->
      O_HANDLER == $past(I_DBG_HANDLER) && O_RET_ADDR == $past(I_PC_OLD)) // RL2
    else $error("debug halt handler not from debug unit");
  a_data_bus_err: assert property (s_took(P_BED) |->
      O_HANDLER == $past(st.event_vector_base) + 32'h8 && O_RET_ADDR == $past(I_PC_OLD)) // RL3
    else $error("data bus error vector wrong");
  a_instr_bus_err: assert property (s_took(P_BEI) |->
      O_HANDLER == $past(st.event_vector_base) + 32'hc && O_RET_ADDR == $past(I_PC_OLD)) // RL4
    else $error("instruction bus error vector wrong");
  a_fault_ret_pc: assert property ((O_TAKE && cepv_ret_kind(O_PRIO) == CEPV_RET_OFFEND) |->
      O_RET_ADDR == $past(sel_pc)) // RL5
    else $error("fault return address not offending pc");
  a_int_autovector: assert property ((O_TAKE && O_PRIO >= P_INT3 && O_PRIO <= P_INT0) |->
      O_HANDLER == $past(st.event_vector_base) + 32'($past(I_AUTOVEC))) // RL6
    else $error("interrupt handler not autovectored");
  a_level_mask_set: assert property (s_took(P_INT3) |->
      O_SR_MASK[SR_I3M:SR_I0M] == 4'hf) // RL7
    else $error("level mask bits not set on accept");
  a_oldest_first: assert property ((!st.boot && old_hit) |=> O_TAKE && O_TAKEN_OLD) // RL9
    else $error("younger instruction served before oldest");
  a_unused_never: assert property (O_TAKE |->
      !(O_PRIO == 5'h13 || O_PRIO == 5'h14 || O_PRIO == 5'h1c)) // RL10
    else $error("event from an absent unit was raised");
endmodule

// ==== design/cepv_pkg.sv ====
// Constants for the CPU event priority and vectoring block.
// Assumes a 32-bit program counter and an AXI4-Lite register port.
package cepv_pkg;
  // Event table shape
  localparam int EVT_N = 28;
  localparam int IDX_W = 5;
  localparam int AUTOVEC_W = 14;
  localparam int ADDR_W = 8;
  localparam logic [31:0] RESET_VEC = 32'h8000_0000;
  localparam logic [31:0] SCALL_STEP = 32'h0000_0002;

  // Priorities with special handling
  localparam logic [IDX_W-1:0] P_RESET = 5'h01;
  localparam logic [IDX_W-1:0] P_DBG = 5'h02;
  localparam logic [IDX_W-1:0] P_BED = 5'h05;
  localparam logic [IDX_W-1:0] P_BEI = 5'h06;
  localparam logic [IDX_W-1:0] P_NMI = 5'h07;
  localparam logic [IDX_W-1:0] P_INT3 = 5'h08;
  localparam logic [IDX_W-1:0] P_INT0 = 5'h0b;
  localparam logic [IDX_W-1:0] P_SCALL = 5'h15;

  // Bit i stands for priority i+1; reset and absent units are no request lines
  localparam logic [EVT_N-1:0] EVT_NONSRC = 28'h80c0001;

  // Status mask bits
  localparam int SR_W = 6;
  localparam int SR_GM = 0;
  localparam int SR_EM = 1;
  localparam int SR_I0M = 2;
  localparam int SR_I3M = 5;
  localparam logic [SR_W-1:0] SR_MASK_RST = 6'h3f;

  // Sticky event status bits
  localparam int ST_W = 3;
  localparam int ST_EXC = 0;
  localparam int ST_INT = 1;
  localparam int ST_DBG = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_EVENT_VECTOR_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SRMASK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_HANDLER = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RETADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PRIO = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_STS = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_MSK = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CEPV_RET_UNDEF = 2'b00,
    CEPV_RET_OFFEND = 2'b01,
    CEPV_RET_FIRST = 2'b10,
    CEPV_RET_SCALL = 2'b11
  } cepv_ret_t;

  // Handler offset from the vector base, by priority
  function automatic logic [8:0] cepv_offset(input logic [IDX_W-1:0] prio);
    case (prio)
      5'h03: cepv_offset = 9'h000;
      5'h04: cepv_offset = 9'h004;
      5'h05: cepv_offset = 9'h008;
      5'h06: cepv_offset = 9'h00c;
      5'h07: cepv_offset = 9'h010;
      5'h0c: cepv_offset = 9'h014;
      5'h0d: cepv_offset = 9'h050;
      5'h0e: cepv_offset = 9'h018;
      5'h0f: cepv_offset = 9'h01c;
      5'h10: cepv_offset = 9'h020;
      5'h11: cepv_offset = 9'h024;
      5'h12: cepv_offset = 9'h028;
      5'h13: cepv_offset = 9'h02c;
      5'h14: cepv_offset = 9'h030;
      5'h15: cepv_offset = 9'h100;
      5'h16: cepv_offset = 9'h034;
      5'h17: cepv_offset = 9'h038;
      5'h18: cepv_offset = 9'h060;
      5'h19: cepv_offset = 9'h070;
      5'h1a: cepv_offset = 9'h03c;
      5'h1b: cepv_offset = 9'h040;
      5'h1c: cepv_offset = 9'h044;
      default: cepv_offset = 9'h000;
    endcase
  endfunction

  // Which return address an event stores
  function automatic cepv_ret_t cepv_ret_kind(input logic [IDX_W-1:0] prio);
    case (prio)
      5'h02, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0f:
        cepv_ret_kind = CEPV_RET_FIRST;
      5'h15: cepv_ret_kind = CEPV_RET_SCALL;
      5'h01: cepv_ret_kind = CEPV_RET_UNDEF;
      default: cepv_ret_kind = CEPV_RET_OFFEND;
    endcase
  endfunction
endpackage

// ==== design/cepv_prio_enc.sv ====
// Fixed priority encoder: lowest set bit wins.
// Assumes a combinational request vector on the caller's clock.
`timescale 1ns/1ps
module cepv_prio_enc #(
  parameter int N = 28,
  parameter int W = 5
) (
  input wire logic [N-1:0] i_req,
  output logic o_found,
  output logic [W-1:0] o_index
);
  // Scan from the top down so the lowest index is kept last
  always_comb begin
    o_found = |i_req;
    o_index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_index = W'(i);
      end
    end
  end
endmodule

// ==== tb/cepv_far_model.sv ====
// Far-side model: interrupt controller and on-chip debug unit.
// Assumes take and priority come from the event block on the same clock.
`timescale 1ns/1ps
module cepv_far_model
  import cepv_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_take,
  input wire logic [IDX_W-1:0] i_prio,
  input wire logic [4:0] i_raise,
  input wire logic [AUTOVEC_W-1:0] i_av,
  input wire logic [31:0] i_dbg,
  output logic [4:0] o_req,
  output logic [AUTOVEC_W-1:0] o_autovec,
  output logic [31:0] o_dbg_handler
);
  logic [4:0] held;
  logic [4:0] done;

  // Slot 0 is debug halt, slots 1..4 are levels 3..0 (priority 8..11)
  always_comb begin
    done = '0;
    done[0] = i_take && (i_prio == P_DBG);
    for (int k = 1; k < 5; k++) begin
      done[k] = i_take && (i_prio == P_INT3 + k - 1);
    end
  end

  // Pending until accepted; a masked request simply keeps waiting
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      held <= '0;
    end else begin
      held <= (held | i_raise) & ~done;
    end
  end

  // Dropped in the take cycle itself, otherwise it would be taken twice
  assign o_req = held & ~done;
  assign o_autovec = i_av;
  assign o_dbg_handler = i_dbg;
endmodule

// ==== tb/tb_cpu_event_priority_vectoring.sv ====
// Self-checking bench for the event priority and vectoring block.
// Assumes the far-side model for interrupt and debug requests.
`timescale 1ns/1ps
module tb_cpu_event_priority_vectoring;
  import cepv_pkg::*;
  // Handler offsets by priority, and the slots that never request
  localparam logic [8:0] OFS [28] = '{9'h0, 9'h0, 9'h0, 9'h4, 9'h8, 9'hc, 9'h10, 9'h0, 9'h0,
    9'h0, 9'h0, 9'h14, 9'h50, 9'h18, 9'h1c, 9'h20, 9'h24, 9'h28, 9'h2c, 9'h30, 9'h100, 9'h34,
    9'h38, 9'h60, 9'h70, 9'h3c, 9'h40, 9'h44};
  localparam logic [27:0] IGN = 28'h80c0001;
  localparam logic [27:0] FIRST = 28'h00047f2;
  logic I_CLOCK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic [27:0] ev_old = '0;
  logic [27:0] I_EVT_YOUNG = '0;
  logic [27:0] I_EVT_OLD;
  logic [31:0] I_PC_OLD = '0;
  logic [31:0] I_PC_YOUNG = '0;
  logic [31:0] event_vector_base = '0;
  logic [31:0] dbg = '0;
  logic [31:0] rd;
  logic [31:0] I_WDATA = '0;
  logic [31:0] I_DBG_HANDLER;
  logic [13:0] av = '0;
  logic [13:0] I_AUTOVEC;
  logic [4:0] raise = '0;
  logic [4:0] req;
  logic [7:0] I_AWADDR = '0;
  logic [7:0] I_ARADDR = '0;
  logic [3:0] I_WSTRB = 4'hf;
  logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_ARVALID = 1'b0, I_BREADY = 1'b1, I_RREADY = 1'b1;
  logic O_TAKE, O_TAKEN_OLD, O_IRQ, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [4:0] O_PRIO;
  logic [31:0] O_HANDLER, O_RET_ADDR, O_RDATA;
  logic [5:0] O_SR_MASK;
  logic [1:0] O_BRESP, O_RRESP, rsp;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int p;

  // Interrupt and debug requests ride on the oldest instruction
  assign I_EVT_OLD = ev_old | {17'h0, req[4:1], 5'h0, req[0], 1'b0};

  cepv_core cepv_core_inst (.I_CLOCK, .I_SYS_RST, .I_EVT_OLD, .I_EVT_YOUNG, .I_PC_OLD,
    .I_PC_YOUNG, .I_DBG_HANDLER, .I_AUTOVEC, .O_TAKE, .O_PRIO, .O_HANDLER, .O_RET_ADDR,
    .O_TAKEN_OLD, .O_SR_MASK, .O_IRQ, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB,
    .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY,
    .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY);
  cepv_far_model cepv_far_model_inst (.i_clk(I_CLOCK), .i_rst(I_SYS_RST), .i_take(O_TAKE),
    .i_prio(O_PRIO), .i_raise(raise), .i_av(av), .i_dbg(dbg), .o_req(req),
    .o_autovec(I_AUTOVEC), .o_dbg_handler(I_DBG_HANDLER));

  always #25 I_CLOCK = ~I_CLOCK;

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge I_CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Both channels offered together, each released when taken; entered after a rising edge
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    while (!(aw && w)) begin
      @(posedge I_CLOCK);
      if (I_AWVALID && O_AWREADY) begin
        aw = 1;
        I_AWVALID <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w = 1;
        I_WVALID <= 1'b0;
      end
    end
    while (O_BVALID !== 1'b1) @(posedge I_CLOCK);
    rsp = O_BRESP;
  endtask

  task axi_rd(input logic [7:0] a);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    @(posedge I_CLOCK);
    while (O_ARREADY !== 1'b1) @(posedge I_CLOCK);
    I_ARVALID <= 1'b0;
    while (O_RVALID !== 1'b1) @(posedge I_CLOCK);
    rd = O_RDATA;
    rsp = O_RRESP;
  endtask

  function automatic int win(input logic [27:0] v);
    for (int i = 0; i < 28; i++) if (v[i] && !IGN[i]) return i + 1;
    return 0;
  endfunction

  function automatic logic [27:0] rnd_vec();
    return 28'($urandom & $urandom & $urandom) & ~28'h0000783;
  endfunction

  // One edge: predict the winner, drop its line at that same edge, check the result
  task step();
    bit fo;
    logic [31:0] sel;
    @(posedge I_CLOCK);
    fo = win(I_EVT_OLD) != 0;
    p = fo ? win(I_EVT_OLD) : win(I_EVT_YOUNG);
    sel = fo ? I_PC_OLD : I_PC_YOUNG;
    if (p != 0 && fo) ev_old <= ev_old & ~(28'h1 << (p - 1));
    else if (p != 0) I_EVT_YOUNG <= I_EVT_YOUNG & ~(28'h1 << (p - 1));
    @(negedge I_CLOCK);
    chk(O_TAKE, p != 0);
    if (p != 0) begin
      chk(O_PRIO, p);
      chk(O_HANDLER, event_vector_base + OFS[p-1]);
      chk(O_RET_ADDR, FIRST[p-1] ? I_PC_OLD : (p == 21 ? sel + 32'h2 : sel));
      chk(O_TAKEN_OLD, fo);
    end
  endtask

  // Raise far-side requests, then expect one take (or none when pe is 0)
  task int_case(input logic [4:0] r, input int pe, input logic [5:0] m);
    bit got;
    got = 0;
    @(posedge I_CLOCK);
    raise <= r;
    @(posedge I_CLOCK);
    raise <= '0;
    repeat (8) begin
      @(negedge I_CLOCK);
      if (O_TAKE === 1'b1) begin
        got = 1;
        chk(O_PRIO, pe);
        chk(O_HANDLER, pe == 2 ? dbg : event_vector_base + av);
        chk(O_RET_ADDR, I_PC_OLD);
        chk(O_SR_MASK, m);
      end
    end
    chk(got, pe != 0);
  endtask

  task irq_chk(input logic e);
    repeat (3) @(posedge I_CLOCK);
    chk(O_IRQ, e);
  endtask

  initial begin
    void'($urandom(58701));
    av = 14'($urandom);
    dbg = $urandom & 32'hffff_fffc;
    repeat (12) @(posedge I_CLOCK);
    I_SYS_RST <= 1'b0;
    @(posedge I_CLOCK);
    @(negedge I_CLOCK);
    chk(O_TAKE, 1);
    chk(O_PRIO, 1);
    chk(O_HANDLER, 32'h8000_0000);
    @(posedge I_CLOCK);
    axi_rd(REG_SRMASK);
    chk(rd, 32'h3f);
    axi_rd(8'h1c);
    chk(rsp, RESP_SLVERR);
    axi_wr(8'h20, 32'h0);
    chk(rsp, RESP_SLVERR);
    // Corner cases first: scall on old beats bus errors on young; absent units alone on old
    for (int n = 0; n < 40; n++) begin
      @(posedge I_CLOCK);
      event_vector_base = $urandom;
      axi_wr(REG_EVENT_VECTOR_BASE, event_vector_base);
      event_vector_base[1:0] = 2'h0;
      ev_old <= n == 0 ? 28'h0100000 : (n == 1 ? 28'h80c0000 : rnd_vec());
      I_EVT_YOUNG <= n == 0 ? 28'h0000030 : rnd_vec();
      I_PC_OLD <= $urandom;
      I_PC_YOUNG <= $urandom;
      do step(); while (p != 0);
    end
    @(posedge I_CLOCK);
    axi_rd(REG_EVENT_VECTOR_BASE);
    chk(rd, event_vector_base);
    // Levels: accept, refuse while masked, preempt, debug ignores masks
    axi_wr(REG_SRMASK, 32'h0);
    int_case(5'h10, 11, 6'h04);
    int_case(5'h10, 0, 6'h04);
    int_case(5'h02, 8, 6'h3c);
    int_case(5'h01, 2, 6'h3c);
    @(posedge I_CLOCK);
    axi_wr(REG_SRMASK, 32'h0);
    axi_wr(REG_PRIO, 32'h0);
    chk(rsp, RESP_OKAY);
    axi_rd(REG_PRIO);
    chk(rd, 11);
    @(posedge I_CLOCK);
    ev_old <= 28'h0000040;
    step();
    chk(O_SR_MASK, 6'h3f);
    // Sticky status, mask and the level interrupt
    @(posedge I_CLOCK);
    axi_rd(REG_IRQ_STS);
    chk(rd, 32'h7);
    axi_wr(REG_IRQ_MSK, 32'h2);
    irq_chk(1'b1);
    axi_wr(REG_IRQ_STS, 32'h2);
    irq_chk(1'b0);
    axi_wr(REG_IRQ_MSK, 32'h5);
    irq_chk(1'b1);
    axi_wr(REG_IRQ_STS, 32'h5);
    irq_chk(1'b0);
    report_and_stop();
  end
endmodule
